// ---- common/sfm_pkg.sv ----
// Constants and types shared by the serial flash master
package sfm_pkg;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_ERASE     = 8'h20;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_STATUS    = 8'h05;
  localparam logic [7:0] FILL_BYTE    = 8'h00;
  // 64 Mb flash is 8 MB, 23 address bits inside the 24-bit field
  localparam int         ADDR_W       = 23;
  localparam int         LEN_W        = 23;
  localparam int         SUM_W        = 32;
  localparam int         WIP_BIT      = 0;
  localparam logic [1:0] ADDR_LAST    = 2'h2;
  localparam logic [1:0] SIG_LAST     = 2'h2;
  // Serial clock and link timing
  localparam int         SCK_HZ       = 39_000_000;
  localparam int         LINK_DIV     = 4;
  localparam int         LINK_HZ      = SCK_HZ * LINK_DIV;
  localparam logic [2:0] CS_GAP       = 3'h4;
  localparam int         BYTE_CYC     = 8 * LINK_DIV;

  typedef enum logic [2:0] {
    CMD_SIG, CMD_READ, CMD_SPLASH, CMD_PATTERN, CMD_ERASE, CMD_PROG, CMD_SUM, CMD_CFG
  } sfm_op_type;

  typedef struct packed {
    sfm_op_type        op;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
    logic [3:0]        sel;
  } sfm_cmd_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } sfm_xfer_type;
endpackage

// ---- hdl/sfm_link.sv ----
// Byte shifter on the link clock driving the flash serial pins
`timescale 1ns/1ps
module sfm_link
  import sfm_pkg::*;
(
  input  wire logic         link_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         req_tgl_i,
  input  wire sfm_xfer_type xfer_i,
  output logic              ack_tgl_o,
  output logic [7:0]        rx_byte_o,
  output logic              sck_o,
  output logic              cs_n_o,
  output logic              pico_o,
  input  wire logic         poci_i
);
  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_GAP} sfm_lstate_type;

  logic           rst_s1, rst_s2, ce_s1, ce_s2, req_s1, req_s2, poci_s1, poci_s2;
  sfm_lstate_type state_reg, state_next;
  logic [7:0]     sh_reg, sh_next, rx_reg, rx_next;
  logic [2:0]     bit_reg, bit_next, gap_reg, gap_next;
  logic [1:0]     ph_reg, ph_next;
  logic           seen_reg, seen_next, last_reg, last_next, ack_reg, ack_next;
  logic           sck_reg, sck_next, cs_n_reg, cs_n_next, pico_reg, pico_next;

  always_ff @(posedge link_clk_i) begin
    rst_s1  <= rst_n_i;
    rst_s2  <= rst_s1;
    ce_s1   <= ce_i;
    ce_s2   <= ce_s1;
    req_s1  <= req_tgl_i;
    req_s2  <= req_s1;
    poci_s1 <= poci_i;
    poci_s2 <= poci_s1;
  end

  always_comb begin
    state_next = state_reg;
    sh_next    = sh_reg;
    rx_next    = rx_reg;
    bit_next   = bit_reg;
    gap_next   = gap_reg;
    ph_next    = ph_reg;
    seen_next  = seen_reg;
    last_next  = last_reg;
    ack_next   = ack_reg;
    sck_next   = 1'b0;
    cs_n_next  = cs_n_reg;
    pico_next  = pico_reg;
    unique case (state_reg)
      L_IDLE: begin
        if (req_s2 != seen_reg) begin
          seen_next  = req_s2;
          sh_next    = xfer_i.data;
          last_next  = xfer_i.last;
          cs_n_next  = 1'b0;
          pico_next  = xfer_i.data[7];
          bit_next   = 3'h7;
          ph_next    = 2'h0;
          state_next = L_SHIFT;
        end
      end
      L_SHIFT: begin
        ph_next  = ph_reg + 2'h1;
        // High for phases zero and one, low otherwise
        sck_next = (ph_reg == 2'h0) || (ph_reg == 2'h1);
        if (ph_reg == 2'h3) begin
          sh_next   = {sh_reg[6:0], poci_s2};
          pico_next = sh_reg[6];
          bit_next  = bit_reg - 3'h1;
          if (bit_reg == 3'h0) begin
            rx_next  = {sh_reg[6:0], poci_s2};
            ack_next = ~ack_reg;
            if (last_reg) begin
              cs_n_next  = 1'b1;
              gap_next   = CS_GAP;
              state_next = L_GAP;
            end else begin
              state_next = L_IDLE;
            end
          end
        end
      end
      L_GAP: begin
        gap_next = gap_reg - 3'h1;
        if (gap_reg == 3'h1) begin
          state_next = L_IDLE;
        end
      end
      default: state_next = L_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i) begin
    if (!rst_s2) begin
      state_reg <= L_IDLE;
      sh_reg    <= 8'h00;
      rx_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      gap_reg   <= 3'h0;
      ph_reg    <= 2'h0;
      seen_reg  <= 1'b0;
      last_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      pico_reg  <= 1'b0;
    end else if (ce_s2) begin
      state_reg <= state_next;
      sh_reg    <= sh_next;
      rx_reg    <= rx_next;
      bit_reg   <= bit_next;
      gap_reg   <= gap_next;
      ph_reg    <= ph_next;
      seen_reg  <= seen_next;
      last_reg  <= last_next;
      ack_reg   <= ack_next;
      sck_reg   <= sck_next;
      cs_n_reg  <= cs_n_next;
      pico_reg  <= pico_next;
    end
  end

  assign ack_tgl_o = ack_reg;
  assign rx_byte_o = rx_reg;
  assign sck_o     = sck_reg;
  assign cs_n_o    = cs_n_reg;
  assign pico_o    = pico_reg;

  sequence s_start;
    (state_reg == L_IDLE) && (req_s2 != seen_reg);
  endsequence

  property p_sck_idle;
    @(posedge link_clk_i) disable iff (!rst_s2) (state_reg != L_SHIFT) |=> !sck_reg;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck high outside a byte");

  property p_cs_frame;
    @(posedge link_clk_i) disable iff (!rst_s2) sck_reg |-> !cs_n_reg;
  endproperty
  a_cs_frame: assert property (p_cs_frame) else $error("sck pulse without select");

  property p_sck_shape;
    @(posedge link_clk_i) disable iff (!rst_s2 || !ce_s2) $rose(sck_reg) |=> sck_reg ##1 !sck_reg;
  endproperty
  a_sck_shape: assert property (p_sck_shape) else $error("sck high time wrong");

  property p_pico_stable;
    @(posedge link_clk_i) disable iff (!rst_s2) sck_reg |-> $stable(pico_reg);
  endproperty
  a_pico_stable: assert property (p_pico_stable) else $error("pico moved while sck high");

  property p_byte_time;
    @(posedge link_clk_i) disable iff (!rst_s2 || !ce_s2) s_start |-> ##33 $changed(ack_reg);
  endproperty
  a_byte_time: assert property (p_byte_time) else $error("byte not done in 32 cycles");
endmodule // sfm_link

// ---- hdl/sfm_master.sv ----
// Serial configuration flash master: command sequencer and clock crossing
//
// Operation
// - Every transfer uses SPI mode zero
// - Serial clock runs nominally at 39 MHz
// - Fast read 0x0B, signature read 0xAB
// - Read streams bytes after one start address
// - Addressing covers flash up to 64 Mb
// - Erase and program operations are issued
// - No page, block or sector size imposed
// - Hold and write-protect pins never driven
// - Splash command fetches selected splash image
// - Test-pattern command reads fixed pattern image
// - Configuration loads from flash at power-up
// - Self-test sums range into 32 bits
`timescale 1ns/1ps
module sfm_master
  import sfm_pkg::*;
#(
  parameter logic [ADDR_W-1:0] CFG_BASE     = 23'h000000,
  parameter logic [LEN_W-1:0]  CFG_LEN      = 23'h000400,
  parameter logic [ADDR_W-1:0] SPLASH_BASE  = 23'h100000,
  parameter logic [ADDR_W-1:0] SPLASH_SIZE  = 23'h040000,
  parameter logic [ADDR_W-1:0] PATTERN_BASE = 23'h080000,
  parameter logic [LEN_W-1:0]  PATTERN_LEN  = 23'h040000
)(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          link_clk_i,
  input  wire logic          cmd_valid_i,
  input  wire sfm_cmd_type   cmd_i,
  output logic               cmd_ready_o,
  input  wire logic          wr_valid_i,
  input  wire logic [7:0]    wr_data_i,
  output logic               wr_ready_o,
  output logic               rd_valid_o,
  output logic [7:0]         rd_data_o,
  output sfm_op_type         rd_src_o,
  output logic               busy_o,
  output logic               done_o,
  output logic               cfg_done_o,
  output logic [7:0]         sig_o,
  output logic [SUM_W-1:0]   sum_o,
  output logic               flash_sck_o,
  output logic               flash_cs_n_o,
  output logic               flash_pico_o,
  output logic               flash_oe_o,
  input  wire logic          flash_poci_i
);
  typedef enum logic [3:0] {
    S_BOOT, S_IDLE, S_WREN, S_INSTR, S_ADDR, S_DUMMY, S_DATA, S_POLL, S_POLLRD, S_DONE
  } sfm_state_type;

  function automatic logic is_read(input sfm_op_type op);
    is_read = (op == CMD_READ) || (op == CMD_SPLASH) || (op == CMD_PATTERN) ||
              (op == CMD_SUM) || (op == CMD_CFG);
  endfunction

  sfm_state_type     state_reg, state_next;
  sfm_op_type        op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [LEN_W-1:0]  len_reg, len_next;
  logic [1:0]        cnt_reg, cnt_next;
  logic              pend_reg, pend_next, seen_reg, seen_next, req_reg, req_next;
  sfm_xfer_type      xfer_reg, xfer_next;
  logic              rdv_reg, rdv_next, done_reg, done_next;
  logic              cfg_reg, cfg_next, oe_reg, oe_next;
  logic [7:0]        rd_reg, rd_next, sig_reg, sig_next;
  logic [SUM_W-1:0]  sum_reg, sum_next;
  logic              ack_tgl, ack_s1, ack_s2, ack_ev, issue, last;
  logic [7:0]        rx_byte, tx;
  logic [23:0]       addr24;

  assign ack_ev = (ack_s2 != seen_reg);
  // Top address bit is zero: 64 Mb is the largest part addressed
  assign addr24 = {1'b0, addr_reg};

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    len_next   = len_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    seen_next  = seen_reg;
    req_next   = req_reg;
    xfer_next  = xfer_reg;
    rdv_next   = 1'b0;
    done_next  = 1'b0;
    cfg_next   = cfg_reg;
    oe_next    = 1'b1;
    rd_next    = rd_reg;
    sig_next   = sig_reg;
    sum_next   = sum_reg;
    issue      = 1'b1;
    last       = 1'b0;
    tx         = FILL_BYTE;
    unique case (state_reg)
      S_BOOT: begin
        issue      = 1'b0;
        op_next    = CMD_CFG;
        addr_next  = CFG_BASE;
        len_next   = CFG_LEN;
        state_next = S_INSTR;
      end
      S_IDLE: begin
        issue = 1'b0;
        if (cmd_valid_i) begin
          op_next   = cmd_i.op;
          addr_next = cmd_i.addr;
          len_next  = (cmd_i.len == '0) ? LEN_W'(1) : cmd_i.len;
          sum_next  = '0;
          if (cmd_i.op == CMD_SPLASH) begin
            addr_next = SPLASH_BASE + ADDR_W'(cmd_i.sel * SPLASH_SIZE);
            len_next  = LEN_W'(SPLASH_SIZE);
          end
          if (cmd_i.op == CMD_PATTERN) begin
            addr_next = PATTERN_BASE;
            len_next  = PATTERN_LEN;
          end
          if (cmd_i.op == CMD_SIG) begin
            len_next = LEN_W'(1);
          end
          // Write enable leads every erase and program
          state_next = (cmd_i.op == CMD_ERASE || cmd_i.op == CMD_PROG) ? S_WREN : S_INSTR;
        end
      end
      S_WREN: begin
        tx   = OP_WREN;
        last = 1'b1;
        if (ack_ev) state_next = S_INSTR;
      end
      S_INSTR: begin
        unique case (op_reg)
          CMD_SIG:   tx = OP_SIGNATURE;
          CMD_ERASE: tx = OP_ERASE;
          CMD_PROG:  tx = OP_PROG;
          default:   tx = OP_FAST_READ;
        endcase
        if (ack_ev) begin
          cnt_next   = (op_reg == CMD_SIG) ? SIG_LAST : ADDR_LAST;
          state_next = (op_reg == CMD_SIG) ? S_DUMMY : S_ADDR;
        end
      end
      S_ADDR: begin
        tx   = addr24[cnt_reg*8 +: 8];
        // Erase size is whatever the part's own sector is
        last = (op_reg == CMD_ERASE) && (cnt_reg == 2'h0);
        if (ack_ev) begin
          cnt_next = cnt_reg - 2'h1;
          if (cnt_reg == 2'h0) begin
            cnt_next   = 2'h0;
            state_next = (op_reg == CMD_ERASE) ? S_POLL :
                         (op_reg == CMD_PROG) ? S_DATA : S_DUMMY;
          end
        end
      end
      S_DUMMY: begin
        if (ack_ev) begin
          cnt_next = cnt_reg - 2'h1;
          if (cnt_reg == 2'h0) state_next = S_DATA;
        end
      end
      S_DATA: begin
        issue = (op_reg != CMD_PROG) || wr_valid_i;
        tx    = (op_reg == CMD_PROG) ? wr_data_i : FILL_BYTE;
        last  = (len_reg == LEN_W'(1));
        if (ack_ev) begin
          // No new address per byte: the part increments
          len_next = len_reg - LEN_W'(1);
          if (is_read(op_reg)) begin
            rdv_next = 1'b1;
            rd_next  = rx_byte;
          end
          if (op_reg == CMD_SUM) sum_next = sum_reg + SUM_W'(rx_byte);
          if (op_reg == CMD_SIG) sig_next = rx_byte;
          if (len_reg == LEN_W'(1)) state_next = (op_reg == CMD_PROG) ? S_POLL : S_DONE;
        end
      end
      S_POLL: begin
        tx = OP_STATUS;
        if (ack_ev) state_next = S_POLLRD;
      end
      S_POLLRD: begin
        last = 1'b1;
        if (ack_ev) state_next = rx_byte[WIP_BIT] ? S_POLL : S_DONE;
      end
      S_DONE: begin
        issue      = 1'b0;
        done_next  = 1'b1;
        cfg_next   = cfg_reg || (op_reg == CMD_CFG);
        state_next = S_IDLE;
      end
      default: begin
        issue      = 1'b0;
        state_next = S_IDLE;
      end
    endcase
    // Held request word and toggle cross to the link domain
    if (issue && !pend_reg) begin
      req_next  = ~req_reg;
      xfer_next = '{data: tx, last: last};
      pend_next = 1'b1;
    end
    if (ack_ev) begin
      pend_next = 1'b0;
      seen_next = ack_s2;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_BOOT;
      op_reg    <= CMD_CFG;
      addr_reg  <= '0;
      len_reg   <= '0;
      cnt_reg   <= 2'h0;
      pend_reg  <= 1'b0;
      seen_reg  <= 1'b0;
      req_reg   <= 1'b0;
      xfer_reg  <= '0;
      rdv_reg   <= 1'b0;
      done_reg  <= 1'b0;
      cfg_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      rd_reg    <= 8'h00;
      sig_reg   <= 8'h00;
      sum_reg   <= '0;
      ack_s1    <= 1'b0;
      ack_s2    <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      len_reg   <= len_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      seen_reg  <= seen_next;
      req_reg   <= req_next;
      xfer_reg  <= xfer_next;
      rdv_reg   <= rdv_next;
      done_reg  <= done_next;
      cfg_reg   <= cfg_next;
      oe_reg    <= oe_next;
      rd_reg    <= rd_next;
      sig_reg   <= sig_next;
      sum_reg   <= sum_next;
      ack_s1    <= ack_tgl;
      ack_s2    <= ack_s1;
    end
  end

  // Link clock is four times the 39 MHz serial clock
  sfm_link u_link (
    .link_clk_i (link_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .req_tgl_i  (req_reg),
    .xfer_i     (xfer_reg),
    .ack_tgl_o  (ack_tgl),
    .rx_byte_o  (rx_byte),
    .sck_o      (flash_sck_o),
    .cs_n_o     (flash_cs_n_o),
    .pico_o     (flash_pico_o),
    .poci_i     (flash_poci_i)
  );

  // Only clock, select and data pins are driven; hold and protect are not
  assign flash_oe_o  = oe_reg;
  assign cmd_ready_o = (state_reg == S_IDLE);
  assign wr_ready_o  = (state_reg == S_DATA) && (op_reg == CMD_PROG) && !pend_reg;
  assign busy_o      = (state_reg != S_IDLE);
  assign rd_valid_o  = rdv_reg;
  assign rd_data_o   = rd_reg;
  assign rd_src_o    = op_reg;
  assign done_o      = done_reg;
  assign cfg_done_o  = cfg_reg;
  assign sig_o       = sig_reg;
  assign sum_o       = sum_reg;

  sequence s_instr_issue;
    (state_reg == S_INSTR) && !pend_reg && ce_i;
  endsequence

  property p_read_op;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_instr_issue ##0 is_read(op_reg) |=> (xfer_reg.data == OP_FAST_READ);
  endproperty
  a_read_op: assert property (p_read_op) else $error("read opcode wrong");

  property p_sig_op;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_instr_issue ##0 (op_reg == CMD_SIG) |=> (xfer_reg.data == OP_SIGNATURE);
  endproperty
  a_sig_op: assert property (p_sig_op) else $error("signature opcode wrong");

  property p_oe_reset;
    @(posedge ref_clk_i) !rst_n_i |=> !flash_oe_o;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pins driven in reset");

  property p_boot;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_reg == S_BOOT && ce_i) |=> (state_reg == S_INSTR && op_reg == CMD_CFG
                                         && addr_reg == CFG_BASE);
  endproperty
  a_boot: assert property (p_boot) else $error("boot load not started");

  property p_sum;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_reg == S_DATA && ack_ev && op_reg == CMD_SUM && ce_i)
        |=> (sum_reg == $past(sum_reg) + SUM_W'($past(rx_byte)));
  endproperty
  a_sum: assert property (p_sum) else $error("checksum not updated");

  property p_stream;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_valid_o |-> (state_reg == S_DATA || state_reg == S_DONE) && is_read(op_reg);
  endproperty
  a_stream: assert property (p_stream) else $error("read byte outside data phase");
endmodule // sfm_master

// ---- verif/sfm_flash_model.sv ----
// Behavioural serial NOR flash answering the flash master
`timescale 1ns/1ps
module sfm_flash_model
  import sfm_pkg::*;
#(
  parameter logic [7:0] SIG_VAL = 8'h3C  // Arbitrary signature value
)(
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic pico_i,
  output logic      poci_o
);
  // Hold and write-protect sit on board pull-ups, so no pins here
  logic [7:0]  mem [logic [23:0]];
  logic [7:0]  sh, op, nxt, last_op;
  logic [23:0] addr, start;
  int          bitc, cnt, last_cnt, busy;
  logic        wel;

  function automatic logic [7:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  initial begin
    poci_o = 1'b0;
    wel = 1'b0;
    busy = 0;
    bitc = 0;
    cnt = 0;
  end

  always @(negedge cs_n_i) begin
    bitc = 0;
    cnt = 0;
    nxt = 8'hFF;
  end

  // Frame end: erase a 4 KB sector, start busy time, leave line inverted
  always @(posedge cs_n_i) begin
    last_cnt = cnt;
    last_op = op;
    if (op == OP_ERASE && cnt == 4 && wel) begin
      for (int i = 0; i < 4096; i++) mem[{addr[23:12], 12'h000} + 24'(i)] = 8'hFF;
    end
    if ((op == OP_ERASE || op == OP_PROG) && wel && cnt >= 4) begin
      wel = 1'b0;
      busy = 2;
    end
    if (op == OP_WREN && cnt == 1) wel = 1'b1;
    poci_o = ~poci_o;
  end

  always @(posedge sck_i) if (!cs_n_i) begin
    sh = {sh[6:0], pico_i};
    bitc++;
    if (bitc == 8) begin
      bitc = 0;
      if (cnt == 0) op = sh;
      else if (cnt < 4) addr = {addr[15:0], sh};
      else if (op == OP_PROG && wel) begin
        mem[addr] = rd(addr) & sh;
        addr++;
      end
      cnt++;
      if (cnt == 4) start = addr;
      if (op == 8'h0B && cnt >= 5) begin
        nxt = rd(addr);
        addr++;
      end
      else if (op == 8'hAB && cnt >= 4) nxt = SIG_VAL;
      else if (op == OP_STATUS) begin
        nxt = {7'h00, busy != 0};
        if (busy != 0) busy--;
      end
      else nxt = ~sh;
    end
  end

  // Output bit changes a little after the falling edge
  always @(negedge sck_i) if (!cs_n_i) #5 poci_o = nxt[7 - bitc];
endmodule // sfm_flash_model

// ---- verif/tb.sv ----
// Self-checking bench for the serial flash master
`timescale 1ns/1ps
module tb;
  import sfm_pkg::*;
  localparam logic [7:0]  SIG_VAL = 8'h3C;  // Arbitrary signature value
  localparam logic [22:0] SLEN    = 23'h000004;
  logic             ref_clk_i, link_clk_i, rst_n_i, ce_i, cmd_valid_i, wr_valid_i;
  sfm_cmd_type      cmd_i;
  logic [7:0]       wr_data_i, rd_data_o, sig_o, bb;
  logic             cmd_ready_o, wr_ready_o, rd_valid_o, busy_o, done_o, cfg_done_o;
  logic             flash_sck_o, flash_cs_n_o, flash_pico_o, flash_oe_o, flash_poci_i;
  sfm_op_type       rd_src_o;
  logic [SUM_W-1:0] sum_o, sum_e;
  logic             sck_w, cs_w, pico_w, rdy_s, vld_s;
  logic [10:0]      exp_q[$], exp_v;
  logic [7:0]       wr_q[$];
  logic [7:0]       shadow [logic [22:0]];
  int               bad_count, cmp_count;
  logic [16:0]      seed;
  realtime          t_r, t_f;

  assign sck_w  = flash_oe_o ? flash_sck_o : 1'b0;
  assign cs_w   = flash_oe_o ? flash_cs_n_o : 1'b1;
  assign pico_w = flash_oe_o ? flash_pico_o : 1'b1;

  sfm_master #(.CFG_LEN(SLEN), .SPLASH_SIZE(SLEN), .PATTERN_LEN(SLEN)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_src_o(rd_src_o), .busy_o(busy_o),
    .done_o(done_o), .cfg_done_o(cfg_done_o), .sig_o(sig_o), .sum_o(sum_o),
    .flash_sck_o(flash_sck_o), .flash_cs_n_o(flash_cs_n_o), .flash_pico_o(flash_pico_o),
    .flash_oe_o(flash_oe_o), .flash_poci_i(flash_poci_i));

  sfm_flash_model #(.SIG_VAL(SIG_VAL)) u_flash (
    .sck_i(sck_w), .cs_n_i(cs_w), .pico_i(pico_w), .poci_o(flash_poci_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #13;
    forever #40 link_clk_i = ~link_clk_i;
  end

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (s !== 1'b1 && k < 60000);
    if (k >= 60000) begin
      bad_count++;
      $display("FAIL wait expected 1 seen 0");
      finish_test();
    end
  endtask

  task automatic run_cmd(input sfm_op_type op, input logic [22:0] a, input logic [22:0] n,
                         input logic [3:0] s);
    cmd_i = '{op, a, n, s};
    cmd_valid_i = 1'b1;
    wait_hi(cmd_ready_o);
    @(posedge ref_clk_i);
    #1 cmd_valid_i = 1'b0;
    chk("busy", 1, busy_o);
    wait_hi(done_o);
    @(posedge ref_clk_i);
    #1;
    chk("idle", 0, busy_o);
  endtask

  task automatic rd_chk(input sfm_op_type op, input logic [22:0] a, input logic [22:0] ea,
                        input logic [22:0] n, input logic [3:0] s);
    logic [22:0] x;
    sum_e = '0;
    for (int i = 0; i < n; i++) begin
      x = ea + 23'(i);
      bb = shadow.exists(x) ? shadow[x] : (x[7:0] ^ x[15:8] ^ 8'h5A);
      sum_e += 32'(bb);
      exp_q.push_back({op, bb});
    end
    if (op != CMD_CFG) run_cmd(op, a, n, s);
    else wait_hi(cfg_done_o);
    chk("rd_left", 0, exp_q.size());
    chk("frame_op", 8'h0B, u_flash.last_op);
    chk("frame_len", 5 + n, u_flash.last_cnt);
    chk("frame_addr", {1'b0, ea}, u_flash.start);
  endtask

  task automatic reset_boot();
    rst_n_i = 1'b0;
    @(posedge ref_clk_i);
    repeat (64) begin
      @(negedge ref_clk_i);
      chk("oe_in_reset", 0, flash_oe_o);
    end
    @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    rd_chk(CMD_CFG, 23'h0, 23'h0, SLEN, 4'h0);
  endtask

  // Scoreboard: every read byte against the oldest note
  always @(negedge ref_clk_i) if (rd_valid_o === 1'b1 && ce_i === 1'b1) begin
    exp_v = exp_q.size() != 0 ? exp_q.pop_front() : 11'h7FF;
    chk("rd_byte", exp_v, {rd_src_o, rd_data_o});
  end

  // Serial pin timing in mode 0
  always @(negedge link_clk_i) if (cs_w === 1'b1) chk("sck_idle", 0, sck_w);
  always @(posedge sck_w) begin
    t_r = $realtime;
    if (rst_n_i === 1'b1 && t_r - t_f < 159.0)
      chk("sck_low_ns", 160, int'(t_r - t_f));
  end
  always @(negedge sck_w) begin
    t_f = $realtime;
    if (rst_n_i === 1'b1 && t_f - t_r < 159.0)
      chk("sck_high_ns", 160, int'(t_f - t_r));
  end
  always @(pico_w) if (sck_w === 1'b1 && cs_w === 1'b0) chk("pico_edge", 0, 1);

  // Program byte feeder, handshake sampled mid-cycle
  always @(negedge ref_clk_i) begin
    rdy_s = wr_ready_o;
    vld_s = wr_valid_i;
  end
  always @(posedge ref_clk_i) begin
    if (vld_s === 1'b1 && rdy_s === 1'b1 && ce_i === 1'b1 && wr_q.size() != 0)
      void'(wr_q.pop_front());
    #1;
    wr_valid_i = wr_q.size() != 0;
    wr_data_i = wr_q.size() != 0 ? wr_q[0] : seed[7:0];
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    seed = 17'h1502A;
    {rst_n_i, cmd_valid_i, wr_valid_i, vld_s, rdy_s} = '0;
    ce_i = 1'b1;
    cmd_i = '0;
    wr_data_i = 8'h00;
    t_r = 0;
    t_f = 0;
    @(posedge ref_clk_i);
    #1;
    reset_boot();
    run_cmd(CMD_SIG, 23'h0, 23'h1, 4'h0);
    chk("sig", SIG_VAL, sig_o);
    chk("sig_op", 8'hAB, u_flash.last_op);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      rd_chk(CMD_READ, {6'h00, seed}, {6'h00, seed}, 23'(seed[2:0]) + 23'h1, 4'h0);
    end
    rd_chk(CMD_READ, 23'h7FFFFE, 23'h7FFFFE, 23'h2, 4'h0);
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      rd_chk(CMD_SPLASH, {6'h00, seed}, 23'h100000 + SLEN * 23'(s), SLEN, 4'(s));
    end
    fork
      rd_chk(CMD_PATTERN, 23'h0, 23'h080000, SLEN, 4'h0);
      begin
        repeat (700) @(posedge ref_clk_i);
        #1 ce_i = 1'b0;
        repeat (40) @(posedge ref_clk_i);
        #1 ce_i = 1'b1;
      end
    join
    rd_chk(CMD_SUM, 23'h001230, 23'h001230, SLEN, 4'h0);
    chk("sum", sum_e, sum_o);
    run_cmd(CMD_ERASE, 23'h200010, 23'h1, 4'h0);
    for (int i = 0; i < 6; i++) shadow[23'h200010 + 23'(i)] = 8'hFF;
    rd_chk(CMD_READ, 23'h200010, 23'h200010, 23'h6, 4'h0);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr_q.push_back(seed[7:0]);
      shadow[23'h200012 + 23'(i)] = seed[7:0];
    end
    run_cmd(CMD_PROG, 23'h200012, 23'h3, 4'h0);
    chk("prog_left", 0, wr_q.size());
    rd_chk(CMD_READ, 23'h200010, 23'h200010, 23'h6, 4'h0);
    reset_boot();
    finish_test();
  end
endmodule // tb
